// File: bench/irqr_host_model.sv
// Purpose: host side of the interrupt pins
// Assumes: pins and strobes share clk_sys
// Notes: counts pin rises and high cycles
`timescale 1ns/1ps
`default_nettype none
module irqr_host_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// pins, bit 0 is output one
	input wire logic [3:0] pins,
	// control: bit 0 reads a, bit 1 reads b a cycle later
	input wire logic [1:0] rd_req,
	input wire logic clr_cnt,
	// strobes and counts
	output logic rd_a,
	output logic rd_b,
	output logic [3:0][7:0] rise_r,
	output logic [3:0][7:0] high_r
);
	logic b_pend_r;
	logic [3:0] prev_r;
	// a first, then b, the order a host driver uses
	always_ff @(posedge clk_sys) begin
		rd_a <= !rst && rd_req[0];
		b_pend_r <= !rst && rd_req[1];
		rd_b <= !rst && b_pend_r;
	end
	// counters sample every edge so no short pulse is missed
	always_ff @(posedge clk_sys) begin
		prev_r <= pins;
		for (int k = 0; k < 4; k++) begin
			rise_r[k] <= clr_cnt ? 8'h00 : rise_r[k] + 8'(pins[k] && !prev_r[k]);
			high_r[k] <= clr_cnt ? 8'h00 : high_r[k] + 8'(pins[k]);
		end
	end
endmodule : irqr_host_model
`default_nettype wire

// File: bench/irqr_sva.sv
// Purpose: port checker for irqr_top
// Assumes: bench runs PULSE_CYC 4 and PERIOD_CYC 8
// Notes: shadows the page and the three routing registers
`timescale 1ns/1ps
`default_nettype none
module irqr_sva #(
	parameter int PULSE_CYC = 4,
	parameter int PERIOD_CYC = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// register access
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_rdata,
	// strobes and sources
	input wire logic latched_status_a_rd,
	input wire logic latched_status_b_rd,
	input wire logic [3:0] dsp_irq_src,
	// pins
	input wire logic irq_out_one,
	input wire logic irq_out_two,
	input wire logic irq_out_three,
	input wire logic irq_out_four
);
	logic [7:0] pg_r;
	logic [7:0] rg_r [3];
	logic [7:0] exp_rd;
	logic [3:0] pin, hit, m3;
	logic [1:0] st;
	int hi_r;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ********************
	// shadow model
	// ********************
	// page gates only the three routing registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pg_r <= 8'h01;
			rg_r <= '{default: 8'h00};
		end else if (reg_wr_en) begin
			if (reg_addr == 8'h00) pg_r <= reg_wdata;
			if (pg_r == 8'h01 && reg_addr inside {8'h70, 8'h71, 8'h72}) rg_r[reg_addr[1:0]] <= reg_wdata;
		end
	end
	// combined value per pin and expected read data
	always_comb begin
		hit = 4'h0;
		exp_rd = 8'h00;
		if (reg_addr == 8'h00) exp_rd = pg_r;
		else if (pg_r == 8'h01 && reg_addr inside {8'h70, 8'h71, 8'h72}) exp_rd = rg_r[reg_addr[1:0]];
		for (int k = 0; k < 4; k++) begin
			m3[k] = rg_r[2][7-2*k -: 2] == 2'h3;
			for (int s = 0; s < 4; s++) hit[k] = hit[k] | (dsp_irq_src[s] && rg_r[s/2][(s%2 ? 2 : 6) -: 3] == 3'(k+1));
		end
	end
	assign pin = {irq_out_four, irq_out_three, irq_out_two, irq_out_one};
	assign st = rg_r[2][7:6];
	// length of the current high stretch on pin one
	always_ff @(posedge clk_sys) hi_r <= (rst || !irq_out_one) ? 0 : hi_r + 1;
	sequence no_b4;
		!latched_status_b_rd [*4];
	endsequence
	sequence gap_low;
		!irq_out_one ##1 !irq_out_one ##1 !irq_out_one ##1 irq_out_one;
	endsequence
	// ********************
	// assertions
	// ********************
	rd_back_a: assert property (reg_rd_en |=> reg_rdata == $past(exp_rd))
		else $error("read data differs from shadow");
	rd_hold_a: assert property (!reg_rd_en |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	live_pin_a: assert property (((pin ^ $past(hit)) & $past(m3)) == 4'h0)
		else $error("live pin not following sources");
	single_rise_a: assert property (st == 2'h0 && $rose(hit[0]) && !irq_out_one && !$past(irq_out_one) |-> ##1 !irq_out_one ##1 irq_out_one)
		else $error("pulse did not start on time");
	pulse_width_a: assert property ($fell(irq_out_one) && st < 2'h2 |-> hi_r == PULSE_CYC)
		else $error("pulse width wrong");
	repeat_gap_a: assert property (no_b4 ##0 ($fell(irq_out_one) && st == 2'h1) ##1 !latched_status_b_rd |-> gap_low)
		else $error("repeat gap wrong");
	hold_level_a: assert property (st == 2'h2 && irq_out_one && !$past(latched_status_b_rd, 2) |=> irq_out_one)
		else $error("held level dropped");
	clear_time_a: assert property (st == 2'h2 && irq_out_one && latched_status_b_rd && $past(latched_status_a_rd) |-> ##2 irq_out_one ##1 !irq_out_one)
		else $error("clear timing wrong");
endmodule : irqr_sva
bind irqr_top irqr_sva #(.PULSE_CYC(PULSE_CYC), .PERIOD_CYC(PERIOD_CYC)) u_sva (
	.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
	.reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .latched_status_a_rd(latched_status_a_rd),
	.latched_status_b_rd(latched_status_b_rd), .dsp_irq_src(dsp_irq_src), .irq_out_one(irq_out_one),
	.irq_out_two(irq_out_two), .irq_out_three(irq_out_three), .irq_out_four(irq_out_four));
`default_nettype wire

// File: bench/tb.sv
// Purpose: self-checking bench for irqr_top
// Assumes: short counts, pulse 4 and period 8 cycles
// Notes: all stimulus by non-blocking assignment at the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int PULSE = 4;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr_en = 1'b0;
	logic reg_rd_en = 1'b0;
	logic [7:0] reg_rdata;
	logic [3:0] dsp_irq_src = 4'h0;
	logic [3:0] pins;
	logic [1:0] rd_req = 2'h0;
	logic clr_cnt = 1'b0;
	logic rd_a, rd_b;
	logic [3:0][7:0] rise_r, high_r;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	always #5 clk_sys = ~clk_sys;
	irqr_top #(.PULSE_CYC(PULSE), .PERIOD_CYC(8)) DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
		.latched_status_a_rd(rd_a), .latched_status_b_rd(rd_b), .dsp_irq_src(dsp_irq_src),
		.irq_out_one(pins[0]), .irq_out_two(pins[1]), .irq_out_three(pins[2]), .irq_out_four(pins[3]));
	irqr_host_model u_host (.clk_sys(clk_sys), .rst(rst), .pins(pins), .rd_req(rd_req), .clr_cnt(clr_cnt),
		.rd_a(rd_a), .rd_b(rd_b), .rise_r(rise_r), .high_r(high_r));
	// ********************
	// shared tasks
	// ********************
	task automatic results;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results
	task automatic chk(input logic [7:0] got, input logic [7:0] e);
		checks_done++;
		if (got !== e) begin
			num_errors++;
			$display("Error at %0t: saw %h want %h", $time, got, e);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge clk_sys);
		reg_wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge clk_sys);
		reg_rd_en <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask : rd
	task automatic src(input logic [3:0] v);
		@(posedge clk_sys);
		dsp_irq_src <= v;
	endtask : src
	task automatic host(input logic [1:0] r, input logic z);
		@(posedge clk_sys);
		rd_req <= r;
		clr_cnt <= z;
		@(posedge clk_sys);
		rd_req <= 2'h0;
		clr_cnt <= 1'b0;
	endtask : host
	// ********************
	// scenarios
	// ********************
	task automatic t_regs;
		rd(8'h00, 8'h01);
		rd(8'h71, 8'h00);
		rd(8'h72, 8'h00);
		wr(8'h00, 8'h02);
		wr(8'h72, 8'hff);
		rd(8'h72, 8'h00);
		wr(8'h00, 8'h01);
		rd(8'h72, 8'h00);
		wr(8'h71, 8'h88);
		rd(8'h71, 8'h88);
		rd(8'h74, 8'h00);
		$display("test regs done");
	endtask : t_regs
	// selected pin live, the rest single pulse, all live for codes with no pin: a misplaced field shows
	task automatic t_route;
		logic [3:0] e;
		for (int s = 0; s < 4; s++) begin
			for (int c = 0; c < 8; c++) begin
				e = (c >= 1 && c <= 4) ? 4'h1 << (c - 1) : 4'h0;
				wr(s < 2 ? 8'h70 : 8'h71, 8'(c) << (s % 2 ? 0 : 4));
				wr(8'h72, e == 4'h0 ? 8'hff : 8'h03 << (8 - 2 * c));
				src(4'h1 << s);
				tick(6);
				chk({4'h0, pins}, {4'h0, e});
				src(4'h0);
				tick(3);
			end
			wr(s < 2 ? 8'h70 : 8'h71, 8'h00);
		end
		$display("test route done");
	endtask : t_route
	task automatic t_or;
		wr(8'h71, 8'h22);
		wr(8'h72, 8'h30);
		src(4'h4);
		src(4'hc);
		src(4'h8);
		tick(3);
		chk({7'h0, pins[1]}, 8'h01);
		src(4'h0);
		tick(3);
		chk({7'h0, pins[1]}, 8'h00);
		wr(8'h71, 8'h10);
		$display("test or done");
	endtask : t_or
	task automatic t_single;
		wr(8'h72, 8'h00);
		host(2'h0, 1'b1);
		src(4'h4);
		tick(1);
		src(4'h0);
		src(4'h4);
		tick(12);
		chk(rise_r[0], 8'h01);
		chk(high_r[0], 8'(PULSE));
		src(4'h0);
		$display("test single done");
	endtask : t_single
	task automatic t_repeat;
		wr(8'h72, 8'h40);
		host(2'h0, 1'b1);
		src(4'h4);
		tick(25);
		chk(rise_r[0], 8'h03);
		chk(high_r[0], 8'(3 * PULSE));
		host(2'h3, 1'b0);
		tick(12);
		chk(rise_r[0], 8'h04);
		src(4'h0);
		$display("test repeat done");
	endtask : t_repeat
	task automatic t_hold;
		wr(8'h72, 8'h80);
		src(4'h4);
		tick(10);
		chk({7'h0, pins[0]}, 8'h01);
		host(2'h1, 1'b0);
		tick(6);
		chk({7'h0, pins[0]}, 8'h01);
		host(2'h3, 1'b0);
		tick(8);
		chk({7'h0, pins[0]}, 8'h00);
		src(4'h0);
		$display("test hold done");
	endtask : t_hold
	// hang guard, well above the run length
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			results();
		end
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs();
		t_route();
		t_or();
		t_single();
		t_repeat();
		t_hold();
		results();
	end
endmodule : tb
`default_nettype wire

// File: rtl/irqr_pkg.sv
// Purpose: shared constants and types for the interrupt routing and pin signalling block
// Assumes: 100 MHz system clock, 8-bit paged register space, book 0 only
// Notes: cycle counts derive from the pulse times and the clock rate

`default_nettype none

package irqr_pkg;

	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int CLK_MHZ = 100;
	localparam int PULSE_MS = 2;
	localparam int PERIOD_MS = 4;
	localparam int PULSE_CYC_DEF = PULSE_MS * CLK_MHZ * 1000;
	localparam int PERIOD_CYC_DEF = PERIOD_MS * CLK_MHZ * 1000;
	localparam int CNT_W = 19;

	// ************************************************************
	// register space
	// ************************************************************
	localparam logic [7:0] ADDR_PAGE_SEL = 8'h00;
	localparam logic [7:0] ADDR_ROUTE_12 = 8'h70;
	localparam logic [7:0] ADDR_ROUTE_34 = 8'h71;
	localparam logic [7:0] ADDR_PIN_STYLE = 8'h72;
	localparam logic [7:0] PAGE_IRQ = 8'h01;
	localparam logic [7:0] PAGE_SEL_RESET = 8'h01;
	localparam logic [7:0] ROUTE_12_RESET = 8'h00;
	localparam logic [7:0] ROUTE_34_RESET = 8'h00;
	localparam logic [7:0] PIN_STYLE_RESET = 8'h00;

	// field positions: upper routing field at 6-4, lower at 2-0
	localparam int ROUTE_HI_LSB = 4;
	localparam int ROUTE_LO_LSB = 0;
	localparam int ROUTE_W = 3;
	// style fields: output one at 7-6 down to output four at 1-0
	localparam int STYLE_W = 2;
	localparam int STYLE_ONE_LSB = 6;
	localparam int NUM_OUT = 4;
	localparam int NUM_SRC = 4;

	// ************************************************************
	// encodings
	// ************************************************************
	localparam logic [2:0] ROUTE_NONE = 3'h0;
	localparam logic [2:0] ROUTE_OUT_FIRST = 3'h1;
	localparam logic [2:0] ROUTE_OUT_LAST = 3'h4;

	localparam logic [1:0] STYLE_ONE_PULSE = 2'h0;
	localparam logic [1:0] STYLE_REPEAT = 2'h1;
	localparam logic [1:0] STYLE_HOLD = 2'h2;
	localparam logic [1:0] STYLE_LIVE = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SINGLE = 2'b01,
		ST_REPEAT = 2'b10,
		ST_HOLD = 2'b11
	} irqr_state_t;

endpackage : irqr_pkg

`default_nettype wire

// File: rtl/irqr_pulse_timer.sv
// Purpose: pulse and period counter for one interrupt output
// Assumes: restart and run come from logic on the same clock
// Notes: counter clears to zero on the first edge it is not running and stays there

`timescale 1ns/1ps
`default_nettype none

module irqr_pulse_timer #(
	parameter int PULSE_CYC = irqr_pkg::PULSE_CYC_DEF,
	parameter int PERIOD_CYC = irqr_pkg::PERIOD_CYC_DEF
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// control
	input wire logic restart,
	input wire logic run,
	// status
	output logic pulse_hi,
	output logic pulse_end
);
	import irqr_pkg::*;

	localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYC - 1);
	localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYC - 1);
	localparam logic [CNT_W-1:0] PULSE_LEN = CNT_W'(PULSE_CYC);

	logic [CNT_W-1:0] cnt_r;

	// free count within one period, wraps so repeats stay in phase
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_r <= '0;
		end else if (restart || !run) begin
			cnt_r <= '0;
		end else if (cnt_r == PERIOD_LAST) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + CNT_W'(1);
		end
	end

	// high for the first PULSE_CYC cycles of the period
	assign pulse_hi = run && (cnt_r < PULSE_LEN);
	assign pulse_end = run && (cnt_r == PULSE_LAST);

endmodule : irqr_pulse_timer

`default_nettype wire

// File: rtl/irqr_read_tracker.sv
// Purpose: notes reads of both latched status registers and issues one clear
// Assumes: read strobes are one-cycle pulses on the system clock
// Notes: reads may come in either order or in the same cycle

`timescale 1ns/1ps
`default_nettype none

module irqr_read_tracker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// read strobes
	input wire logic rd_a,
	input wire logic rd_b,
	// clear pulse
	output logic clr_pulse
);
	import irqr_pkg::*;

	logic seen_a_r;
	logic seen_b_r;
	logic clr_r;
	logic both_nxt;

	// both seen, counting this cycle's strobes
	assign both_nxt = (seen_a_r || rd_a) && (seen_b_r || rd_b);

	// remember each read until the pair is complete
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			seen_a_r <= 1'b0;
			seen_b_r <= 1'b0;
		end else if (both_nxt) begin
			seen_a_r <= 1'b0;
			seen_b_r <= 1'b0;
		end else begin
			seen_a_r <= seen_a_r || rd_a;
			seen_b_r <= seen_b_r || rd_b;
		end
	end

	// one-cycle clear after the second read
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clr_r <= 1'b0;
		end else begin
			clr_r <= both_nxt;
		end
	end

	assign clr_pulse = clr_r;

endmodule : irqr_read_tracker

`default_nettype wire

// File: rtl/irqr_top.sv
// Purpose: routes four dsp interrupt sources onto four pins and shapes each pin
// Assumes: sources and register strobes are on clk_sys; book 0 is selected
// Notes: pins are registered, so every pin change lags its state or live combined value by one cycle

`timescale 1ns/1ps
`default_nettype none

module irqr_top #(
	parameter int PULSE_CYC = irqr_pkg::PULSE_CYC_DEF,
	parameter int PERIOD_CYC = irqr_pkg::PERIOD_CYC_DEF
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// register access
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd_en,
	output logic [7:0] reg_rdata,
	// latched status read strobes
	input wire logic latched_status_a_rd,
	input wire logic latched_status_b_rd,
	// dsp interrupt sources, bit 0 is source 1
	input wire logic [3:0] dsp_irq_src,
	// interrupt pins
	output logic irq_out_one,
	output logic irq_out_two,
	output logic irq_out_three,
	output logic irq_out_four
);
	import irqr_pkg::*;

	// ************************************************************
	// functions
	// ************************************************************

	// one-hot pin select from a routing code; reserved codes select nothing
	function automatic logic [NUM_OUT-1:0] route_onehot(input logic [2:0] code);
		logic [NUM_OUT-1:0] oh;
		oh = '0;
		if (code >= ROUTE_OUT_FIRST && code <= ROUTE_OUT_LAST) begin
			oh = NUM_OUT'(1) << (code - ROUTE_OUT_FIRST);
		end
		return oh;
	endfunction : route_onehot

	// pin-style field of output k, output one in the top bits
	function automatic logic [1:0] style_of(input logic [7:0] reg_val, input int k);
		logic [1:0] s;
		s = reg_val[(STYLE_ONE_LSB - STYLE_W * k) +: STYLE_W];
		return s;
	endfunction : style_of

	// ************************************************************
	// register file
	// ************************************************************

	// register state and read path
	logic [7:0] page_sel_r;
	logic [7:0] route_12_r;
	logic [7:0] route_34_r;
	logic [7:0] pin_style_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic on_irq_page;

	// routing registers answer only while page 1 is selected
	assign on_irq_page = (page_sel_r == PAGE_IRQ);

	// page select answers at address zero of every page
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			page_sel_r <= PAGE_SEL_RESET;
		end else if (reg_wr_en && reg_addr == ADDR_PAGE_SEL) begin
			page_sel_r <= reg_wdata;
		end
	end

	// routing and style registers; reserved bits are stored as written
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			route_12_r <= ROUTE_12_RESET;
			route_34_r <= ROUTE_34_RESET;
			pin_style_r <= PIN_STYLE_RESET;
		end else if (reg_wr_en && on_irq_page) begin
			if (reg_addr == ADDR_ROUTE_12) begin
				route_12_r <= reg_wdata;
			end
			if (reg_addr == ADDR_ROUTE_34) begin
				route_34_r <= reg_wdata;
			end
			if (reg_addr == ADDR_PIN_STYLE) begin
				pin_style_r <= reg_wdata;
			end
		end
	end

	// read decode; anything not held here reads zero
	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_addr == ADDR_PAGE_SEL) begin
			rdata_nxt = page_sel_r;
		end else if (on_irq_page) begin
			case (reg_addr)
				ADDR_ROUTE_12: rdata_nxt = route_12_r;
				ADDR_ROUTE_34: rdata_nxt = route_34_r;
				ADDR_PIN_STYLE: rdata_nxt = pin_style_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// read data one cycle after the strobe, held until the next read
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_r <= 8'h00;
		end else if (reg_rd_en) begin
			rdata_r <= rdata_nxt;
		end
	end

	// registered read data, so the bus never sees a decode glitch
	assign reg_rdata = rdata_r;

	// ************************************************************
	// routing and combining
	// ************************************************************

	// one-hot pin selects per source and the combined values
	logic [NUM_OUT-1:0] sel_src1;
	logic [NUM_OUT-1:0] sel_src2;
	logic [NUM_OUT-1:0] sel_src3;
	logic [NUM_OUT-1:0] sel_src4;
	logic [NUM_OUT-1:0] comb_irq;
	logic [NUM_OUT-1:0] comb_prev_r;
	logic [NUM_OUT-1:0] irq_event;

	// decode each routing field; reserved codes drop the source
	assign sel_src1 = route_onehot(route_12_r[ROUTE_HI_LSB +: ROUTE_W]);
	assign sel_src2 = route_onehot(route_12_r[ROUTE_LO_LSB +: ROUTE_W]);
	assign sel_src3 = route_onehot(route_34_r[ROUTE_HI_LSB +: ROUTE_W]);
	assign sel_src4 = route_onehot(route_34_r[ROUTE_LO_LSB +: ROUTE_W]);

	// every source routed to a pin contributes to it
	assign comb_irq = (sel_src1 & {NUM_OUT{dsp_irq_src[0]}})
		| (sel_src2 & {NUM_OUT{dsp_irq_src[1]}})
		| (sel_src3 & {NUM_OUT{dsp_irq_src[2]}})
		| (sel_src4 & {NUM_OUT{dsp_irq_src[3]}});

	// rising edge of the combined value is the interrupt event
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			comb_prev_r <= '0;
		end else begin
			comb_prev_r <= comb_irq;
		end
	end

	// events are edges, so a source stuck high cannot retrigger a pin
	// once it has been cleared; it must fall and rise again
	assign irq_event = comb_irq & ~comb_prev_r;

	// ************************************************************
	// latched-condition clear
	// ************************************************************

	// both status reads together give a one-cycle clear for every pin
	logic status_clr;

	// the tracker keeps a partial pair until the other read arrives
	irqr_read_tracker u_read_tracker (
		.clk_sys(clk_sys),
		.rst(rst),
		.rd_a(latched_status_a_rd),
		.rd_b(latched_status_b_rd),
		.clr_pulse(status_clr)
	);

	// ************************************************************
	// per-pin shaping
	// ************************************************************

	// pins are registered so the host never sees decode hazards
	logic [NUM_OUT-1:0] pin_r;

	for (genvar k = 0; k < NUM_OUT; k++) begin : g_pin
		// per-pin state, timer hookup and level
		irqr_state_t state_r;
		irqr_state_t state_nxt;
		logic [1:0] style;
		logic restart;
		logic run;
		logic hi;
		logic last;
		logic pin_nxt;

		// style field of this pin
		assign style = style_of(pin_style_r, k);
		// timer restarts only when a pulsing style takes a fresh event
		assign restart = (state_r == ST_IDLE) && irq_event[k]
			&& (style == STYLE_ONE_PULSE || style == STYLE_REPEAT);
		// timer runs only in the pulsing states, so it idles at zero
		assign run = (state_r == ST_SINGLE) || (state_r == ST_REPEAT);

		// one timer per pin keeps pins independent at the cost of area
		irqr_pulse_timer #(
			.PULSE_CYC(PULSE_CYC),
			.PERIOD_CYC(PERIOD_CYC)
		) u_timer (
			.clk_sys(clk_sys),
			.rst(rst),
			.restart(restart),
			.run(run),
			.pulse_hi(hi),
			.pulse_end(last)
		);

		// next state; a new event beats a clear in the same cycle
		always_comb begin
			state_nxt = state_r;
			case (state_r)
				ST_IDLE: begin
					if (irq_event[k]) begin
						case (style)
							STYLE_ONE_PULSE: state_nxt = ST_SINGLE;
							STYLE_REPEAT: state_nxt = ST_REPEAT;
							STYLE_HOLD: state_nxt = ST_HOLD;
							default: state_nxt = ST_IDLE;
						endcase
					end
				end
				ST_SINGLE: begin
					// further events during the pulse are absorbed
					if (last) begin
						state_nxt = ST_IDLE;
					end
				end
				ST_REPEAT, ST_HOLD: begin
					if (!irq_event[k] && status_clr) begin
						state_nxt = ST_IDLE;
					end
				end
				default: state_nxt = ST_IDLE;
			endcase
		end

		// state register; style changes leave the state alone
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				state_r <= ST_IDLE;
			end else begin
				state_r <= state_nxt;
			end
		end

		// pin level; live style bypasses the latched states
		always_comb begin
			if (style == STYLE_LIVE) begin
				pin_nxt = comb_irq[k];
			end else begin
				case (state_r)
					ST_SINGLE: pin_nxt = 1'b1;
					ST_REPEAT: pin_nxt = hi;
					ST_HOLD: pin_nxt = 1'b1;
					default: pin_nxt = 1'b0;
				endcase
			end
		end

		// one flip-flop per pin; adds a cycle of latency to every style
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				pin_r[k] <= 1'b0;
			end else begin
				pin_r[k] <= pin_nxt;
			end
		end
	end

	// ************************************************************
	// pin outputs
	// ************************************************************

	// bit 0 drives output one, bit 3 output four
	assign irq_out_one = pin_r[0];
	assign irq_out_two = pin_r[1];
	assign irq_out_three = pin_r[2];
	assign irq_out_four = pin_r[3];

endmodule : irqr_top

`default_nettype wire
